// >>> hdl/clkctl_pkg.sv
/* Shared definitions of the core clock control block: register map,
   field positions, strap ratios, timing counts and bus carrier types.
   Assumes an AXI4-Lite master with 32-bit data and 8 address bits. */
package clkctl_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned LOCK_CYCLES = 4096;
  localparam int          LOCK_W      = 16;

  // ==========================================================
  // Register map
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_STAT  = 8'h04;
  localparam logic [7:0]  OFS_SPDIV = 8'h10;
  localparam int          NUM_SPORT = 6;
  localparam int          SPDIV_W   = 16;
  localparam logic [15:0] SPDIV_RST = 16'h0000;

  // ==========================================================
  // Control register fields
  localparam int MULT_LSB   = 0;
  localparam int MULT_W     = 6;
  localparam int DIV_LSB    = 6;
  localparam int INPUT_DIVIDER_BIT  = 8;
  localparam int POST_DIVIDER_ENABLE_BIT  = 9;
  localparam int CLKOUT_BIT = 12;
  localparam int BYP_BIT    = 15;
  localparam int SHDN_LSB   = 27;
  localparam int NUM_PERIPH = 4;
  localparam int PER_TIMER  = 0;
  localparam int PER_SPORT  = 1;
  localparam int PER_PPORT  = 2;
  localparam int PER_SPI    = 3;

  // ==========================================================
  // Status register fields
  localparam int ST_LOCK       = 0;
  localparam int ST_SEQERR     = 1;
  localparam int ST_PINS_LSB   = 2;
  localparam int ST_BYP        = 4;
  localparam int ST_PERIPH_LSB = 12;

  // ==========================================================
  // Strap ratios and bus answers
  localparam logic [5:0] STRAP_M00   = 6'h06;
  localparam logic [5:0] STRAP_M01   = 6'h20;
  localparam logic [5:0] STRAP_M10   = 6'h10;
  localparam logic [5:0] MULT_ONE    = 6'h01;
  localparam logic [4:0] DIV_ONE     = 5'h01;
  localparam logic [1:0] STRAP_TAKE  = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {PLL_LOCKING = 1'b0, PLL_RUNNING = 1'b1} pll_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage

// >>> hdl/clock_power_control.sv
/* Core clock and power control: ratio straps, multiplier and divisor
   programming with bypass, peripheral clock gates, serial port clock
   enables and input synchronisers. Assumes one 20 MHz clock, a
   synchronous reset and an AXI4-Lite master on the register port. */
`timescale 1ns/1ns

// Notes on behaviour
// - Synchronise async inputs through two flip-flops.
// - Power-up ratio from two straps: 32,16,6.
// - Software reprograms ratio through control register.
// - Core clock is input times M over N.
// - Six serial ports divide core clock independently.
// - Peripheral clocks off until initialised; gateable.
// - Divisor enable bit 9, divide-by-four bit 7.
// - Bypass bit sits at bit 15.
// - Clock-out versus reset-out select at bit 12.
// - SPI clock shutdown sits at bit 30.
// - Multiplier eight is bit 3 set.
// - Divisor enable always reads back zero.
// - Bypass runs core directly from input clock.
module clock_power_control
  import clkctl_pkg::*;
#(
  parameter int unsigned LOCK_CNT = LOCK_CYCLES,
  parameter int          SPORTS   = NUM_SPORT
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  input  wire axi_req_t              AXI_REQ_I,
  output axi_rsp_t                   AXI_RSP_O,
  input  wire logic [1:0]            RATIO_SELECT_PINS_I,
  input  wire logic                  EXT_RESET_N_I,
  input  wire logic [2:0]            INTERRUPT_REQUEST_INPUTS_I,
  input  wire logic [11:0]           GENERAL_FLAG_INPUTS_I,
  input  wire logic [NUM_PERIPH-1:0] PERIPH_INIT_I,
  output logic [5:0]                 CORE_MULT_O,
  output logic [4:0]                 CORE_DIV_O,
  output logic                       CORE_BYPASS_O,
  output logic                       PLL_LOCKED_O,
  output logic                       CLKOUT_SELECT_O,
  output logic [NUM_PERIPH-1:0]      PERIPH_CLK_EN_O,
  output logic [SPORTS-1:0]          SPORT_CLK_EN_O,
  output logic                       EXT_RESET_N_O,
  output logic [2:0]                 IRQ_SYNC_O,
  output logic [11:0]                FLAG_SYNC_O
);
  // ==========================================================
  // Input synchronisers
  localparam int          SYN_W   = 18;
  localparam logic [17:0] SYN_RST = 18'h08000;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CNT - 1);

  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic [SYN_W-1:0] syn_d;

  // Pins are sampled in arbitrary phase; a late edge shows one cycle on.
  assign syn_d = {RATIO_SELECT_PINS_I, EXT_RESET_N_I,
                  INTERRUPT_REQUEST_INPUTS_I, GENERAL_FLAG_INPUTS_I};

  // Two stages; only the second stage is read by any logic.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      syn1_q <= SYN_RST;
      syn2_q <= SYN_RST;
    end else begin
      syn1_q <= syn_d;
      syn2_q <= syn1_q;
    end
  end

  assign FLAG_SYNC_O   = syn2_q[11:0];
  assign IRQ_SYNC_O    = syn2_q[14:12];
  assign EXT_RESET_N_O = syn2_q[15];

  // ==========================================================
  // Register state
  logic [5:0]            mult_q,     mult_d;
  logic [5:0]            app_mult_q, app_mult_d;
  logic [1:0]            divc_q,     divc_d;
  logic [1:0]            app_divc_q, app_divc_d;
  logic                  input_divider_q,    input_divider_d;
  logic                  app_input_divider_q, app_input_divider_d;
  logic                  clkout_q,   clkout_d;
  logic                  byp_q,      byp_d;
  logic                  seqerr_q,   seqerr_d;
  logic [NUM_PERIPH-1:0] shdn_q,     shdn_d;
  logic [NUM_PERIPH-1:0] pon_q,      pon_d;
  logic [NUM_PERIPH-1:0] pen_q,      pen_d;
  logic [1:0]            strap_q,    strap_d;
  logic [1:0]            pins_q,     pins_d;
  logic [LOCK_W-1:0]     lock_cnt_q, lock_cnt_d;
  pll_state_t            pll_q,      pll_d;
  logic [5:0]            core_mult_q, core_mult_d;
  logic [4:0]            core_div_q, core_div_d;
  logic [SPDIV_W-1:0]    spdiv_q [SPORTS];
  logic [SPDIV_W-1:0]    spdiv_d [SPORTS];

  // ==========================================================
  // Bus slave state
  logic              aw_have_q, aw_have_d;
  logic              w_have_q,  w_have_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0]       w_data_q,  w_data_d;
  logic [3:0]        w_strb_q,  w_strb_d;
  logic              bvalid_q,  bvalid_d;
  logic [1:0]        bresp_q,   bresp_d;
  logic              rvalid_q,  rvalid_d;
  logic [31:0]       rdata_q,   rdata_d;
  logic [1:0]        rresp_q,   rresp_d;
  logic              rd_ctrl_q, rd_ctrl_d;

  logic        awready, wready, arready;
  logic        aw_take, w_take, ar_take, wr_go;
  logic [31:0] ctrl_rd, stat_rd, old_word, wmask, wv;
  logic        wr_hit, wr_ctrl, wr_stat, strap_take, relock;

  function automatic logic [5:0] strap_mult(input logic [1:0] p);
    case (p)
      2'b01:   strap_mult = STRAP_M01;
      2'b10:   strap_mult = STRAP_M10;
      default: strap_mult = STRAP_M00;
    endcase
  endfunction

  function automatic logic sp_hit(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - OFS_SPDIV;
    sp_hit = (a >= OFS_SPDIV) && (a[1:0] == 2'h0) &&
             (int'(rel[7:2]) < SPORTS);
  endfunction

  function automatic int sp_idx(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - OFS_SPDIV;
    sp_idx = int'(rel[7:2]);
  endfunction

  // Readback words; the divisor enable is a strobe and never reads set.
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[MULT_LSB +: MULT_W]   = mult_q;
    ctrl_rd[DIV_LSB +: 2]         = divc_q;
    ctrl_rd[INPUT_DIVIDER_BIT]            = input_divider_q;
    ctrl_rd[POST_DIVIDER_ENABLE_BIT]            = 1'b0;
    ctrl_rd[CLKOUT_BIT]           = clkout_q;
    ctrl_rd[BYP_BIT]              = byp_q;
    ctrl_rd[SHDN_LSB +: NUM_PERIPH] = shdn_q;
    stat_rd = '0;
    stat_rd[ST_LOCK]              = (pll_q == PLL_RUNNING);
    stat_rd[ST_SEQERR]            = seqerr_q;
    stat_rd[ST_PINS_LSB +: 2]     = pins_q;
    stat_rd[ST_BYP]               = byp_q;
    stat_rd[ST_PERIPH_LSB +: NUM_PERIPH] = pen_q;
  end

  // Handshakes; a pending response blocks new writes until it is taken.
  always_comb begin
    awready  = !aw_have_q && !bvalid_q;
    wready   = !w_have_q && !bvalid_q;
    arready  = !rvalid_q;
    aw_take  = AXI_REQ_I.awvalid && awready;
    w_take   = AXI_REQ_I.wvalid && wready;
    ar_take  = AXI_REQ_I.arvalid && arready;
    wr_go    = aw_have_q && w_have_q && !bvalid_q;
    old_word = '0;
    if (aw_addr_q == OFS_CTRL) begin
      old_word = ctrl_rd;
    end else if (sp_hit(aw_addr_q)) begin
      old_word = 32'(spdiv_q[sp_idx(aw_addr_q)]);
    end
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{w_strb_q[b]}};
    end
    wv      = (old_word & ~wmask) | (w_data_q & wmask);
    wr_ctrl = wr_go && (aw_addr_q == OFS_CTRL);
    wr_stat = wr_go && (aw_addr_q == OFS_STAT);
    wr_hit  = wr_ctrl || wr_stat || sp_hit(aw_addr_q);
  end

  // Bus next state; reads answer one cycle after the address is taken.
  always_comb begin
    aw_have_d = aw_have_q ? !wr_go : aw_take;
    w_have_d  = w_have_q ? !wr_go : w_take;
    aw_addr_d = aw_take ? AXI_REQ_I.awaddr : aw_addr_q;
    w_data_d  = w_take ? AXI_REQ_I.wdata : w_data_q;
    w_strb_d  = w_take ? AXI_REQ_I.wstrb : w_strb_q;
    bvalid_d  = bvalid_q ? !AXI_REQ_I.bready : wr_go;
    bresp_d   = bresp_q;
    if (wr_go) begin
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    rvalid_d  = rvalid_q ? !AXI_REQ_I.rready : ar_take;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    rd_ctrl_d = rd_ctrl_q;
    if (ar_take) begin
      rresp_d   = RESP_OKAY;
      rd_ctrl_d = (AXI_REQ_I.araddr == OFS_CTRL);
      if (AXI_REQ_I.araddr == OFS_CTRL) begin
        rdata_d = ctrl_rd;
      end else if (AXI_REQ_I.araddr == OFS_STAT) begin
        rdata_d = stat_rd;
      end else if (sp_hit(AXI_REQ_I.araddr)) begin
        rdata_d = 32'(spdiv_q[sp_idx(AXI_REQ_I.araddr)]);
      end else begin
        rdata_d = '0;
        rresp_d = RESP_SLVERR;
      end
    end
  end

  // Control next state: straps, programming, lock tracking and gates.
  always_comb begin
    strap_take  = (strap_q == STRAP_TAKE);
    strap_d     = (strap_q == 2'h3) ? strap_q : strap_q + 2'h1;
    pins_d      = strap_take ? syn2_q[17:16] : pins_q;
    mult_d      = mult_q;
    divc_d      = divc_q;
    input_divider_d     = input_divider_q;
    clkout_d    = clkout_q;
    byp_d       = byp_q;
    shdn_d      = shdn_q;
    app_divc_d  = app_divc_q;
    seqerr_d    = seqerr_q;
    spdiv_d     = spdiv_q;
    relock      = strap_take;
    if (strap_take) begin
      mult_d = strap_mult(syn2_q[17:16]);
    end
    if (wr_ctrl) begin
      mult_d   = wv[MULT_LSB +: MULT_W];
      divc_d   = wv[DIV_LSB +: 2];
      input_divider_d  = wv[INPUT_DIVIDER_BIT];
      clkout_d = wv[CLKOUT_BIT];
      byp_d    = wv[BYP_BIT];
      shdn_d   = wv[SHDN_LSB +: NUM_PERIPH];
      // A set divisor enable loads the post divider; it is not stored.
      if (wv[POST_DIVIDER_ENABLE_BIT]) begin
        app_divc_d = wv[DIV_LSB +: 2];
      end
      relock = relock || (mult_d != mult_q) || (input_divider_d != input_divider_q);
    end
    for (int i = 0; i < SPORTS; i++) begin
      if (wr_go && sp_hit(aw_addr_q) && sp_idx(aw_addr_q) == i) begin
        spdiv_d[i] = wv[SPDIV_W-1:0];
      end
    end
    // Misordered programming is flagged; a new error beats the clear.
    if (wr_stat && wv[ST_SEQERR]) begin
      seqerr_d = 1'b0;
    end
    if (wr_ctrl && (wv[BYP_BIT] != byp_q) && wv[POST_DIVIDER_ENABLE_BIT]) begin
      seqerr_d = 1'b1;
    end
    if (wr_ctrl && byp_q && !wv[BYP_BIT] && pll_q != PLL_RUNNING) begin
      seqerr_d = 1'b1;
    end
    pll_d      = pll_q;
    lock_cnt_d = lock_cnt_q;
    case (pll_q)
      PLL_LOCKING: begin
        if (lock_cnt_q == LOCK_LAST) begin
          pll_d = PLL_RUNNING;
        end else begin
          lock_cnt_d = lock_cnt_q + LOCK_W'(1);
        end
      end
      PLL_RUNNING: begin
        pll_d = PLL_RUNNING;
      end
      default: begin
        pll_d = PLL_LOCKING;
      end
    endcase
    if (relock) begin
      pll_d      = PLL_LOCKING;
      lock_cnt_d = '0;
    end
    // The loop ratio reaches the core only while bypassed or when the straps
    // are taken, so a change never glitches the running clock.
    app_mult_d  = (byp_q || strap_take) ? mult_d : app_mult_q;
    app_input_divider_d = (byp_q || strap_take) ? input_divider_d : app_input_divider_q;
    core_mult_d = byp_q ? MULT_ONE : app_mult_q;
    core_div_d  = byp_q ? DIV_ONE :
                  DIV_ONE << ({1'b0, app_divc_q} + {2'b00, app_input_divider_q});
    pon_d = pon_q | PERIPH_INIT_I;
    pen_d = pon_q & ~shdn_q;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      rd_ctrl_q <= 1'b0;
      strap_q   <= '0;
      pins_q    <= '0;
      mult_q    <= STRAP_M00;
      app_mult_q <= STRAP_M00;
      divc_q    <= '0;
      app_divc_q <= '0;
      input_divider_q   <= 1'b0;
      app_input_divider_q <= 1'b0;
      clkout_q  <= 1'b0;
      byp_q     <= 1'b0;
      seqerr_q  <= 1'b0;
      shdn_q    <= '0;
      pon_q     <= '0;
      pen_q     <= '0;
      pll_q     <= PLL_LOCKING;
      lock_cnt_q <= '0;
      core_mult_q <= STRAP_M00;
      core_div_q <= DIV_ONE;
      for (int i = 0; i < SPORTS; i++) begin
        spdiv_q[i] <= SPDIV_RST;
      end
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      rd_ctrl_q <= rd_ctrl_d;
      strap_q   <= strap_d;
      pins_q    <= pins_d;
      mult_q    <= mult_d;
      app_mult_q <= app_mult_d;
      divc_q    <= divc_d;
      app_divc_q <= app_divc_d;
      input_divider_q   <= input_divider_d;
      app_input_divider_q <= app_input_divider_d;
      clkout_q  <= clkout_d;
      byp_q     <= byp_d;
      seqerr_q  <= seqerr_d;
      shdn_q    <= shdn_d;
      pon_q     <= pon_d;
      pen_q     <= pen_d;
      pll_q     <= pll_d;
      lock_cnt_q <= lock_cnt_d;
      core_mult_q <= core_mult_d;
      core_div_q <= core_div_d;
      spdiv_q   <= spdiv_d;
    end
  end

  // ==========================================================
  // Serial port clock enables
  // Each port divides the core rate by its own setting plus one.
  for (genvar i = 0; i < SPORTS; i++) begin : g_sport
    logic [SPDIV_W-1:0] cnt_q, cnt_d;
    logic               tick_q, tick_d;
    always_comb begin
      cnt_d  = cnt_q + SPDIV_W'(1);
      tick_d = 1'b0;
      if (!pen_q[PER_SPORT]) begin
        cnt_d = '0;
      end else if (cnt_q >= spdiv_q[i]) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end
    end
    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        cnt_q  <= '0;
        tick_q <= 1'b0;
      end else begin
        cnt_q  <= cnt_d;
        tick_q <= tick_d;
      end
    end
    assign SPORT_CLK_EN_O[i] = tick_q;
  end

  // Outputs, all from flip-flops except the bus handshakes.
  always_comb begin
    AXI_RSP_O         = '0;
    AXI_RSP_O.awready = awready;
    AXI_RSP_O.wready  = wready;
    AXI_RSP_O.bvalid  = bvalid_q;
    AXI_RSP_O.bresp   = bresp_q;
    AXI_RSP_O.arready = arready;
    AXI_RSP_O.rvalid  = rvalid_q;
    AXI_RSP_O.rdata   = rdata_q;
    AXI_RSP_O.rresp   = rresp_q;
  end
  assign CORE_MULT_O     = core_mult_q;
  assign CORE_DIV_O      = core_div_q;
  assign CORE_BYPASS_O   = byp_q;
  assign PLL_LOCKED_O    = (pll_q == PLL_RUNNING);
  assign CLKOUT_SELECT_O = clkout_q;
  assign PERIPH_CLK_EN_O = pen_q;

  // ==========================================================
  // Assertions
  property p_sync;
    @(posedge CLK_I) disable iff (RST_I)
      !$past(RST_I) && !$past(RST_I, 2) |->
        IRQ_SYNC_O == $past(INTERRUPT_REQUEST_INPUTS_I, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync lag");

  property p_strap;
    @(posedge CLK_I) disable iff (RST_I)
      strap_q == STRAP_TAKE && !wr_ctrl |=>
        mult_q == strap_mult($past(syn2_q[17:16]));
  endproperty
  a_strap: assert property (p_strap) else $error("strap");

  property p_ratio;
    @(posedge CLK_I) disable iff (RST_I)
      !$past(byp_q) |-> CORE_MULT_O == $past(app_mult_q) &&
        CORE_DIV_O == (DIV_ONE << ({1'b0, $past(app_divc_q)} +
                                   {2'b00, $past(app_input_divider_q)}));
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio");

  property p_bypass;
    @(posedge CLK_I) disable iff (RST_I)
      $past(byp_q) |-> CORE_MULT_O == MULT_ONE && CORE_DIV_O == DIV_ONE;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass");

  property p_hold;
    @(posedge CLK_I) disable iff (RST_I)
      !byp_q && strap_q != STRAP_TAKE |=> $stable(app_mult_q);
  endproperty
  a_hold: assert property (p_hold) else $error("ratio moved");

  property p_divrd;
    @(posedge CLK_I) disable iff (RST_I)
      rvalid_q && rd_ctrl_q |-> !rdata_q[POST_DIVIDER_ENABLE_BIT];
  endproperty
  a_divrd: assert property (p_divrd) else $error("post_divider_enable read");

  property p_div4;
    @(posedge CLK_I) disable iff (RST_I)
      wr_ctrl && w_strb_q[1:0] == 2'h3 && w_data_q[POST_DIVIDER_ENABLE_BIT] &&
        w_data_q[DIV_LSB +: 2] == 2'h2 |=> app_divc_q == 2'h2;
  endproperty
  a_div4: assert property (p_div4) else $error("div code");

  property p_byp_bit;
    @(posedge CLK_I) disable iff (RST_I)
      wr_ctrl && w_strb_q[1] |=> byp_q == $past(w_data_q[BYP_BIT]);
  endproperty
  a_byp_bit: assert property (p_byp_bit) else $error("byp bit");

  property p_clkout;
    @(posedge CLK_I) disable iff (RST_I)
      wr_ctrl && w_strb_q[1] |=>
        CLKOUT_SELECT_O == $past(w_data_q[CLKOUT_BIT]);
  endproperty
  a_clkout: assert property (p_clkout) else $error("clkout");

  property p_spi;
    @(posedge CLK_I) disable iff (RST_I)
      wr_ctrl && w_strb_q[3] && w_data_q[SHDN_LSB + PER_SPI] |=>
        ##1 !PERIPH_CLK_EN_O[PER_SPI];
  endproperty
  a_spi: assert property (p_spi) else $error("spi gate");

  property p_pgate;
    @(posedge CLK_I) disable iff (RST_I)
      PERIPH_CLK_EN_O[PER_TIMER] |-> $past(pon_q[PER_TIMER]);
  endproperty
  a_pgate: assert property (p_pgate) else $error("early clock");

  property p_m8;
    @(posedge CLK_I) disable iff (RST_I)
      wr_ctrl && w_strb_q[0] && w_data_q[5:0] == 6'h08 |=> mult_q == 6'h08;
  endproperty
  a_m8: assert property (p_m8) else $error("mult eight");
endmodule

// >>> verif/testbench.sv
/* Self-checking bench for the core clock control block.
   Assumes the package and design from hdl/ and a short lock count. */
`timescale 1ns/1ns
module testbench;
  import clkctl_pkg::*;
  // ==========================================================
  // Stimulus signals and counters
  logic        CLK_I;
  logic        RST_I;
  axi_req_t    rq;
  axi_rsp_t    rs;
  logic [1:0]  pins;
  logic        ext_n;
  logic [2:0]  irq;
  logic [11:0] flg;
  logic [3:0]  init;
  logic [5:0]  mult;
  logic [4:0]  div;
  logic        byp, lck, cko, rsto;
  logic [3:0]  pen;
  logic [5:0]  spe;
  logic [2:0]  irqs;
  logic [11:0] flgs;
  logic [31:0] q;
  logic [1:0]  r;
  int          fails, cmp_count, cyc, n0, n5;

  // Short lock count keeps the run brief.
  clock_power_control #(.LOCK_CNT(16), .SPORTS(6)) dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .AXI_REQ_I(rq), .AXI_RSP_O(rs),
    .RATIO_SELECT_PINS_I(pins), .EXT_RESET_N_I(ext_n),
    .INTERRUPT_REQUEST_INPUTS_I(irq), .GENERAL_FLAG_INPUTS_I(flg),
    .PERIPH_INIT_I(init), .CORE_MULT_O(mult), .CORE_DIV_O(div),
    .CORE_BYPASS_O(byp), .PLL_LOCKED_O(lck), .CLKOUT_SELECT_O(cko),
    .PERIPH_CLK_EN_O(pen), .SPORT_CLK_EN_O(spe), .EXT_RESET_N_O(rsto),
    .IRQ_SYNC_O(irqs), .FLAG_SYNC_O(flgs));

  // ==========================================================
  // Clock and watchdog
  initial begin
    CLK_I = 0;
    forever #25 CLK_I = ~CLK_I;
  end

  // A hang is cut off far beyond the few hundred cycles needed.
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Readies are sampled at the falling edge, so the rising edge that
  // takes a channel is known without racing the design's flops.
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    logic at, wt, art, dn;
    dn = 0;
    @(posedge CLK_I);
    rq.awvalid <= w; rq.wvalid <= w; rq.bready <= w;
    rq.awaddr <= a; rq.wdata <= d; rq.wstrb <= 4'hf;
    rq.arvalid <= !w; rq.araddr <= a; rq.rready <= !w;
    while (!dn) begin
      @(negedge CLK_I);
      at = rq.awvalid & rs.awready;
      wt = rq.wvalid & rs.wready;
      art = rq.arvalid & rs.arready;
      dn = w ? rs.bvalid : rs.rvalid;
      q = rs.rdata;
      r = w ? rs.bresp : rs.rresp;
      @(posedge CLK_I);
      if (at) rq.awvalid <= 0;
      if (wt) rq.wvalid <= 0;
      if (art) rq.arvalid <= 0;
      if (dn) begin
        rq.bready <= 0;
        rq.rready <= 0;
      end
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge CLK_I);
  endtask

  task automatic rst(input logic [1:0] p);
    @(posedge CLK_I);
    RST_I <= 1;
    pins <= p;
    repeat (4) @(posedge CLK_I);
    RST_I <= 0;
    wt(1);
    chk("pen0", pen, 0);
    wt(24);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rq = '0; RST_I = 1; pins = 0; ext_n = 1; irq = 0; flg = 0;
    init = 0; fails = 0; cmp_count = 0; cyc = 0;
    for (int i = 0; i < 3; i++) begin
      rst(i[1:0]);
      chk("strap", mult, i == 0 ? 6 : i == 1 ? 32 : 16);
      chk("lock", lck, 1);
      xf(0, OFS_STAT, 0);
      chk("pins", q[3:2], i);
    end
    // First sequence: divisor, then bypass, lock, leave bypass.
    xf(1, OFS_CTRL, 32'h0000_0288);
    xf(1, OFS_CTRL, 32'h0000_8088);
    wt(3);
    chk("byp", byp, 1);
    chk("relock", lck, 0);
    wt(20);
    chk("lock2", lck, 1);
    xf(1, OFS_CTRL, 32'h0000_0088);
    wt(3);
    chk("mult8", mult, 8);
    chk("div4", div, 4);
    chk("nobyp", byp, 0);
    xf(0, OFS_CTRL, 0);
    chk("post_divider_enable", q, 32'h0000_0088);
    xf(0, OFS_STAT, 0);
    chk("seqok", q[1:0], 2'h1);
    // Clock-out select, peripheral gates and SPI shutdown.
    xf(1, OFS_CTRL, 32'h0000_1088);
    wt(3);
    chk("cko", cko, 1);
    @(posedge CLK_I);
    init <= 4'hf;
    @(posedge CLK_I);
    init <= 4'h0;
    wt(3);
    chk("pen", pen, 4'hf);
    xf(1, OFS_CTRL, 32'h4000_1088);
    wt(3);
    chk("spi", pen, 4'h7);
    // Serial port enables: port 0 divides by 3, port 5 by 5.
    xf(1, OFS_SPDIV, 2);
    xf(1, OFS_SPDIV + 8'h14, 4);
    wt(3);
    n0 = 0;
    n5 = 0;
    repeat (30) begin
      wt(1);
      n0 += spe[0];
      n5 += spe[5];
    end
    chk("sp0", n0, 10);
    chk("sp5", n5, 6);
    // Asynchronous pins pass two synchroniser stages.
    @(posedge CLK_I);
    flg <= 12'ha5c;
    irq <= 3'h5;
    ext_n <= 0;
    wt(1);
    chk("early", flgs, 0);
    wt(3);
    chk("sync", {irqs, flgs, rsto}, {3'h5, 12'ha5c, 1'b0});
    // Second sequence: ratio under bypass, lock, unbypass, then divisor.
    xf(1, OFS_CTRL, 32'h4000_90d0);
    chk("bresp", r, RESP_OKAY);
    wt(20);
    chk("lock3", lck, 1);
    xf(1, OFS_CTRL, 32'h4000_10d0);
    wt(3);
    chk("div4b", div, 5'h04);
    xf(1, OFS_CTRL, 32'h4000_12d0);
    wt(3);
    chk("m16", mult, 6'h10);
    chk("div8", div, 5'h08);
    // A bypass change with the divisor enable set must be flagged, and
    // the flag clears only by writing one to it.
    xf(1, OFS_CTRL, 32'h4000_92d0);
    xf(0, OFS_STAT, 0);
    chk("seqerr", q[1:0], 2'h3);
    xf(1, OFS_STAT, 32'h0000_0002);
    xf(0, OFS_STAT, 0);
    chk("w1c", q[1:0], 2'h1);
    // Unmapped address answers with an error and zero data.
    xf(0, 8'h40, 0);
    chk("unmap_resp", r, RESP_SLVERR);
    chk("unmap_data", q, 32'h0);
    print_verdict();
  end
endmodule
